// ===== rtl/mfo_bank.sv
// mfo_bank: feature and overvoltage configuration bank of a cell monitor
// assumes cell and aux results arrive on REF_CLK_IN from local logic
// and that the host reaches the registers over spi
//
// What this block does
// - bit 5 picks aux reference
// - bit 4 picks aux source
// - aux result scaled to chosen source
// - cell count field encodes six to three
// - unused upper cells ignore overvoltage
// - crc error sets flag, pin unless masked
// - crc disable bit drops packet crc
// - crc checked when chip select rises
// - threshold bit 7 disables overvoltage
// - threshold code is 2 V plus 50 mV steps
// - delay register: unit, reserved, count
// - unit bit picks microseconds or milliseconds
// - count times 100; zero means unlatched
`timescale 1ns/100ps
`default_nettype none
module mfo_bank
  import mfo_pkg::*;
#(
  parameter int         MS_CYC   = 10000,
  parameter logic [5:0] DEV_ADDR = 6'h01
)
(
  input  wire logic              REF_CLK_IN,
  input  wire logic              SYS_RST_IN,
  input  wire logic              SCLK_IN,
  input  wire logic              CS_N_IN,
  input  wire logic              SDI_IN,
  input  wire logic [13:0]       AUX_RAW_IN,
  input  wire logic              AUX_VALID_IN,
  input  wire logic [NCELL*13-1:0] CELL_MV_IN,
  input  wire logic              CRC_FAULT_CLR_IN,
  input  wire logic              OV_FAULT_CLR_IN,
  output logic                   SDO_OUT,
  output logic                   SDO_OE_N_OUT,
  output logic                   AUX_REF_SEL_OUT,
  output logic                   AUX_SRC_SEL_OUT,
  output logic [15:0]            AUX_RESULT_OUT,
  output logic                   CRC_FAULT_OUT,
  output logic [NCELL-1:0]       OV_FAULT_OUT,
  output logic                   FAULT_N_OUT
);

  mfo_cfg_t   cfg;
  mfo_view_t  view;
  mfo_frame_t frame;

  logic       link_rst;
  logic       tog;
  logic       tog_s1;
  logic       tog_s2;
  logic       tog_seen;
  logic       cs_s1;
  logic       cs_s2;
  logic       frame_end;

  logic [7:0] b0;
  logic [7:0] b1;
  logic [7:0] b2;
  logic [7:0] b3;
  logic       short_frame;
  logic       for_me;
  logic       is_wr;
  logic       crc_on;
  logic       crc_ok;
  logic       wr_ok;
  logic       crc_bad;

  logic [3:0]  us_cnt;
  logic [13:0] ms_cnt;
  logic        us_tick;
  logic        ms_tick;
  logic        dly_tick;

  logic [12:0]      ov_mv;
  logic [2:0]       ncells;
  logic [NCELL-1:0] cell_en;
  logic [NCELL-1:0] over;
  logic [NCELL-1:0] ov_fault;

  ////////////////////////////////////////////////////////////////////
  // link domain

  always_ff @(posedge REF_CLK_IN) begin
    link_rst <= SYS_RST_IN;
  end

  mfo_spi_link u_link (
    .sclk_in      (SCLK_IN),
    .rst_in       (link_rst),
    .cs_n_in      (CS_N_IN),
    .sdi_in       (SDI_IN),
    .addr_in      (DEV_ADDR),
    .view_in      (view),
    .frame_out    (frame),
    .tog_out      (tog),
    .sdo_out      (SDO_OUT),
    .sdo_oe_n_out (SDO_OE_N_OUT)
  );

  ////////////////////////////////////////////////////////////////////
  // crossings into the system clock

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      cs_s1  <= 1'b1;
      cs_s2  <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
    end else begin
      cs_s1  <= CS_N_IN;
      cs_s2  <= cs_s1;
      tog_s1 <= tog;
      tog_s2 <= tog_s1;
    end
  end

  // a frame is taken only after chip select has risen again
  assign frame_end = cs_s2 && (tog_s2 != tog_seen);

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN)     tog_seen <= 1'b0;
    else if (frame_end) tog_seen <= tog_s2;
  end

  // view is refreshed only between frames, so the link sees it frozen
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      view <= '0;
    end else if (cs_s2) begin
      view.cfg <= cfg;
      view.aux <= AUX_RESULT_OUT;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // write decode

  // a write without crc leaves its three bytes in the low 24 bits
  assign short_frame = frame.nbits == BITS_WR;
  assign b0 = short_frame ? frame.bits[23:16] : frame.bits[31:24];
  assign b1 = short_frame ? frame.bits[15:8] : frame.bits[23:16];
  assign b2 = short_frame ? frame.bits[7:0] : frame.bits[15:8];
  assign b3 = frame.bits[7:0];

  assign crc_on = ~cfg.io[BIT_CRC_DISABLE_BIT];
  assign is_wr  = b0[0];
  assign for_me = b0[6:1] == DEV_ADDR || b0[6:1] == BCAST_ADDR;
  assign crc_ok = crc8(crc8(crc8(8'h00, b0), b1), b2) == b3;

  always_comb begin
    wr_ok   = 1'b0;
    crc_bad = 1'b0;
    if (frame_end && is_wr && for_me) begin
      if (!crc_on) begin
        wr_ok = frame.nbits == BITS_WR;
      end else if (frame.nbits == BITS_WR_CRC && crc_ok) begin
        wr_ok = 1'b1;
      end else begin
        crc_bad = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////
  // configuration registers

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      cfg.feature <= RST_FEATURE;
      cfg.io      <= RST_IO;
      cfg.ov_thr  <= RST_OV_THR;
      cfg.ov_dly  <= RST_OV_DLY;
    end else if (wr_ok) begin
      case (b1)
        OFS_FEATURE: cfg.feature <= b2 & MSK_FEATURE;
        OFS_IO:      cfg.io      <= b2 & MSK_IO;
        OFS_OV_THR:  cfg.ov_thr  <= b2 & MSK_OV_THR;
        OFS_OV_DLY:  cfg.ov_dly  <= b2 & MSK_OV_DLY;
        default:     cfg.ov_dly  <= cfg.ov_dly;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // aux converter steering

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      AUX_REF_SEL_OUT <= 1'b0;
      AUX_SRC_SEL_OUT <= 1'b0;
    end else begin
      AUX_REF_SEL_OUT <= cfg.feature[BIT_AUX_REF];
      AUX_SRC_SEL_OUT <= cfg.feature[BIT_AUX_SRC];
    end
  end

  // battery source reads through a divider, so rescale it
  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      AUX_RESULT_OUT <= 16'h0000;
    end else if (AUX_VALID_IN) begin
      if (AUX_SRC_SEL_OUT)
        AUX_RESULT_OUT <= 16'((18'(AUX_RAW_IN) * AUX_BAT_NUM)
                              >> AUX_BAT_SHIFT);
      else
        AUX_RESULT_OUT <= {2'b00, AUX_RAW_IN};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // crc fault flag and pin, set wins over clear

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN)            CRC_FAULT_OUT <= 1'b0;
    else if (crc_bad)          CRC_FAULT_OUT <= 1'b1;
    else if (CRC_FAULT_CLR_IN) CRC_FAULT_OUT <= 1'b0;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) begin
      FAULT_N_OUT <= 1'b1;
    end else begin
      FAULT_N_OUT <= ~((CRC_FAULT_OUT
                        && !cfg.io[BIT_PIN_MASK])
                       || |ov_fault);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // delay time base

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || us_tick) us_cnt <= 4'h0;
    else                       us_cnt <= us_cnt + 4'h1;
  end

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN || ms_tick) ms_cnt <= 14'h0000;
    else                       ms_cnt <= ms_cnt + 14'h0001;
  end

  assign us_tick  = us_cnt == 4'(US_CYC - 1);
  assign ms_tick  = ms_cnt == 14'(MS_CYC - 1);
  assign dly_tick = cfg.ov_dly[BIT_DLY_UNIT] ? ms_tick : us_tick;

  ////////////////////////////////////////////////////////////////////
  // overvoltage comparators per cell

  assign ov_mv  = OV_BASE_MV + OV_STEP_MV * {7'h00, cfg.ov_thr[5:0]};
  assign ncells = 3'(NCELL) - {1'b0, cfg.feature[BIT_CELL_HI:BIT_CELL_LO]};

  generate
    for (genvar i = 0; i < NCELL; i++) begin : g_cell
      assign cell_en[i] = (3'(i) < ncells)
                          && !cfg.ov_thr[BIT_OV_DIS];
      assign over[i] = CELL_MV_IN[i*13 +: 13] > ov_mv;

      mfo_ov_delay u_dly (
        .clk_in    (REF_CLK_IN),
        .rst_in    (SYS_RST_IN),
        .tick_in   (dly_tick),
        .over_in   (over[i]),
        .en_in     (cell_en[i]),
        .dcount_in (cfg.ov_dly[4:0]),
        .clr_in    (OV_FAULT_CLR_IN),
        .fault_out (ov_fault[i])
      );
    end
  endgenerate

  always_ff @(posedge REF_CLK_IN) begin
    if (SYS_RST_IN) OV_FAULT_OUT <= '0;
    else            OV_FAULT_OUT <= ov_fault;
  end

endmodule : mfo_bank
`default_nettype wire

// ===== rtl/mfo_pkg.sv
// mfo_pkg: offsets, fields, resets, timing and carriers
// assumes a 10 MHz system clock and an 8-bit spi register space
package mfo_pkg;

  localparam logic [7:0] OFS_AUX_HI  = 8'h01;
  localparam logic [7:0] OFS_AUX_LO  = 8'h02;
  localparam logic [7:0] OFS_FEATURE = 8'h40;
  localparam logic [7:0] OFS_IO      = 8'h41;
  localparam logic [7:0] OFS_OV_THR  = 8'h42;
  localparam logic [7:0] OFS_OV_DLY  = 8'h43;

  localparam logic [7:0] MSK_FEATURE = 8'h3C;
  localparam logic [7:0] MSK_IO      = 8'h81;
  localparam logic [7:0] MSK_OV_THR  = 8'hBF;
  localparam logic [7:0] MSK_OV_DLY  = 8'h9F;

  localparam logic [7:0] RST_FEATURE = 8'h00;
  localparam logic [7:0] RST_IO      = 8'h00;
  localparam logic [7:0] RST_OV_THR  = 8'h00;
  localparam logic [7:0] RST_OV_DLY  = 8'h00;

  localparam int BIT_AUX_REF  = 5;
  localparam int BIT_AUX_SRC  = 4;
  localparam int BIT_CELL_HI  = 3;
  localparam int BIT_CELL_LO  = 2;
  localparam int BIT_PIN_MASK = 7;
  localparam int BIT_CRC_DISABLE_BIT  = 0;
  localparam int BIT_OV_DIS   = 7;
  localparam int BIT_DLY_UNIT = 7;

  localparam logic [5:0]  BCAST_ADDR = 6'h3F;
  localparam logic [7:0]  CRC_POLY   = 8'h07;
  localparam logic [7:0]  BITS_WR    = 8'h18;
  localparam logic [7:0]  BITS_WR_CRC = 8'h20;

  localparam int NCELL = 6;
  localparam logic [12:0] OV_BASE_MV = 13'h07D0;
  localparam logic [12:0] OV_STEP_MV = 13'h0032;
  localparam logic [11:0] DLY_STEP   = 12'h064;

  localparam int CLK_NS = 100;
  localparam int US_NS  = 1000;
  localparam int US_CYC = US_NS / CLK_NS;
  localparam int MS_US  = 1000;

  localparam int AUX_BAT_NUM   = 5;
  localparam int AUX_BAT_SHIFT = 1;

  typedef struct packed {
    logic [7:0] feature;
    logic [7:0] io;
    logic [7:0] ov_thr;
    logic [7:0] ov_dly;
  } mfo_cfg_t;

  typedef struct packed {
    mfo_cfg_t    cfg;
    logic [15:0] aux;
  } mfo_view_t;

  typedef struct packed {
    logic [31:0] bits;
    logic [7:0]  nbits;
  } mfo_frame_t;

  function automatic logic [7:0] crc8(input logic [7:0] c,
                                      input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction : crc8

endpackage : mfo_pkg

// ===== rtl/mfo_spi_link.sv
// mfo_spi_link: spi end of the bank, clocked by the serial clock
// assumes the view input is frozen while chip select is low
`timescale 1ns/100ps
`default_nettype none
module mfo_spi_link
  import mfo_pkg::*;
(
  input  wire logic       sclk_in,
  input  wire logic       rst_in,
  input  wire logic       cs_n_in,
  input  wire logic       sdi_in,
  input  wire logic [5:0] addr_in,
  input  wire mfo_view_t  view_in,
  output var  mfo_frame_t frame_out,
  output logic            tog_out,
  output logic            sdo_out,
  output logic            sdo_oe_n_out
);

  logic       started;
  logic [7:0] txb;
  logic [7:0] crc;
  logic [7:0] cur;
  logic [7:0] c;
  logic [4:0] k;
  logic [2:0] bi;
  logic [7:0] len;
  logic [7:0] base;
  logic       rd_me;
  logic       crc_on;
  logic [3:0] sh;
  logic [23:0] hdr;

  function automatic logic [7:0] reg_rd(input mfo_view_t v,
                                        input logic [7:0] a);
    case (a)
      OFS_AUX_HI:  reg_rd = v.aux[15:8];
      OFS_AUX_LO:  reg_rd = v.aux[7:0];
      OFS_FEATURE: reg_rd = v.cfg.feature;
      OFS_IO:      reg_rd = v.cfg.io;
      OFS_OV_THR:  reg_rd = v.cfg.ov_thr;
      OFS_OV_DLY:  reg_rd = v.cfg.ov_dly;
      default:     reg_rd = 8'h00;
    endcase
  endfunction : reg_rd

  ////////////////////////////////////////////////////////////////////
  // receive side

  // cleared by reset too, so the first frame never sees an unknown
  always_ff @(posedge sclk_in or posedge cs_n_in or posedge rst_in) begin
    if (cs_n_in || rst_in) started <= 1'b0;
    else                   started <= 1'b1;
  end

  always_ff @(posedge sclk_in or posedge rst_in) begin
    if (rst_in)       tog_out <= 1'b0;
    else if (!started) tog_out <= ~tog_out;
  end

  assign c = started ? frame_out.nbits : 8'h00;

  always_ff @(posedge sclk_in) begin
    if (c != 8'hFF) frame_out.nbits <= c + 8'h01;
    if (c < 8'h20) frame_out.bits <= {frame_out.bits[30:0], sdi_in};
  end

  ////////////////////////////////////////////////////////////////////
  // transmit side, read answers

  assign k      = frame_out.nbits[7:3];
  assign bi     = frame_out.nbits[2:0];
  // header keeps moving up until the shifter stops at 32 bits
  assign sh     = (frame_out.nbits > 8'h20) ? 4'h8
                  : 4'(frame_out.nbits - 8'h18);
  assign hdr    = 24'(frame_out.bits >> sh);
  assign base   = hdr[15:8];
  assign len    = hdr[7:0];
  assign crc_on = ~view_in.cfg.io[BIT_CRC_DISABLE_BIT];
  assign rd_me  = hdr[22:17] == addr_in
                  && !hdr[16] && k >= 5'd3;

  // packet size is set by the host request
  always_comb begin
    cur = txb;
    if (bi == 3'd0) begin
      if ({3'b000, k} < 8'd3 + len)
        cur = reg_rd(view_in, base + {3'b000, k} - 8'd3);
      else if ({3'b000, k} == 8'd3 + len && crc_on)
        cur = (k == 5'd3) ? 8'h00 : crc8(crc, txb);
      else
        cur = 8'h00;
    end
  end

  // released as soon as chip select rises, not at the next clock
  always_ff @(negedge sclk_in or posedge rst_in or posedge cs_n_in) begin
    if (rst_in || cs_n_in) sdo_oe_n_out <= 1'b1;
    else                   sdo_oe_n_out <= ~(rd_me & started);
  end

  always_ff @(negedge sclk_in or posedge rst_in) begin
    if (rst_in) begin
      txb          <= 8'h00;
      crc          <= 8'h00;
      sdo_out      <= 1'b0;
    end else begin
      sdo_out      <= cur[3'd7 - bi];
      if (bi == 3'd0) begin
        txb <= cur;
        if (k == 5'd3)      crc <= 8'h00;
        else if (k > 5'd3)  crc <= crc8(crc, txb);
      end
    end
  end

endmodule : mfo_spi_link
`default_nettype wire

// ===== rtl/mfo_ov_delay.sv
// mfo_ov_delay: one cell's overvoltage qualification and latch
// assumes tick pulses once per selected time unit
`timescale 1ns/100ps
`default_nettype none
module mfo_ov_delay
  import mfo_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic       tick_in,
  input  wire logic       over_in,
  input  wire logic       en_in,
  input  wire logic [4:0] dcount_in,
  input  wire logic       clr_in,
  output logic            fault_out
);

  logic [11:0] cnt;
  logic [11:0] target;
  logic        hit;
  logic        latched;

  assign target = 12'(dcount_in * DLY_STEP);
  assign hit    = en_in && over_in && cnt == target;

  always_ff @(posedge clk_in) begin
    if (rst_in || !en_in || !over_in)  cnt <= 12'h000;
    else if (tick_in && cnt != target) cnt <= cnt + 12'h001;
  end

  // set wins over clear
  always_ff @(posedge clk_in) begin
    if (rst_in)                          latched <= 1'b0;
    else if (hit && dcount_in != 5'h00)  latched <= 1'b1;
    else if (clr_in)                     latched <= 1'b0;
  end

  always_ff @(posedge clk_in) begin
    if (rst_in)                  fault_out <= 1'b0;
    else if (dcount_in == 5'h00) fault_out <= en_in && over_in;
    else                         fault_out <= latched;
  end

endmodule : mfo_ov_delay
`default_nettype wire

// ===== bench/mfo_bank_monitor.sv
// mfo_bank_monitor: port checks of the configuration bank
// assumes it is bound onto mfo_bank and sees only its ports
`timescale 1ns/100ps
`default_nettype none
module mfo_bank_monitor
  import mfo_pkg::*;
#(
  parameter int         MS_CYC   = 10000,
  parameter logic [5:0] DEV_ADDR = 6'h01
)
(
  input wire logic                REF_CLK_IN,
  input wire logic                SYS_RST_IN,
  input wire logic                SCLK_IN,
  input wire logic                CS_N_IN,
  input wire logic                SDI_IN,
  input wire logic [13:0]         AUX_RAW_IN,
  input wire logic                AUX_VALID_IN,
  input wire logic [NCELL*13-1:0] CELL_MV_IN,
  input wire logic                CRC_FAULT_CLR_IN,
  input wire logic                OV_FAULT_CLR_IN,
  input wire logic                SDO_OUT,
  input wire logic                SDO_OE_N_OUT,
  input wire logic                AUX_REF_SEL_OUT,
  input wire logic                AUX_SRC_SEL_OUT,
  input wire logic [15:0]         AUX_RESULT_OUT,
  input wire logic                CRC_FAULT_OUT,
  input wire logic [NCELL-1:0]    OV_FAULT_OUT,
  input wire logic                FAULT_N_OUT
);
  logic all_low;
  logic any_fault;
  always_comb begin
    all_low = 1'b1;
    for (int i = 0; i < NCELL; i++) begin
      if (CELL_MV_IN[i*13+:13] > OV_BASE_MV) all_low = 1'b0;
    end
  end
  assign any_fault = CRC_FAULT_OUT | (|OV_FAULT_OUT);
  default clocking cb @(posedge REF_CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  //////////////////////////////////////////////////////////////////////////
  chk_aux_plain: assert property (
    AUX_VALID_IN && !AUX_SRC_SEL_OUT
    |=> AUX_RESULT_OUT == {2'h0, $past(AUX_RAW_IN)})
    else $error("aux result not the raw conversion");
  chk_aux_scaled: assert property (
    AUX_VALID_IN && AUX_SRC_SEL_OUT
    |=> AUX_RESULT_OUT == 16'((17'($past(AUX_RAW_IN)) * 17'h5) >> 1))
    else $error("aux result not scaled for battery pin");
  chk_crc_sticky: assert property (
    CRC_FAULT_OUT && !CRC_FAULT_CLR_IN |=> CRC_FAULT_OUT)
    else $error("crc flag dropped without clear");
  chk_crc_clear: assert property (
    (CS_N_IN && CRC_FAULT_CLR_IN) [*8] |-> !CRC_FAULT_OUT)
    else $error("crc flag survives clear");
  chk_crc_at_end: assert property (
    !CS_N_IN [*6] |=> !$rose(CRC_FAULT_OUT))
    else $error("crc flag raised inside a frame");
  chk_cfg_frame: assert property (
    !CS_N_IN [*6] |=> $stable(AUX_SRC_SEL_OUT) && $stable(AUX_REF_SEL_OUT))
    else $error("selects changed inside a frame");
  chk_ov_quiet: assert property (
    (all_low && OV_FAULT_CLR_IN) [*5] |-> OV_FAULT_OUT == 6'h00)
    else $error("ov fault with no cell above threshold");
  chk_fault_cause: assert property (
    !FAULT_N_OUT |-> ($past(any_fault) || $past(any_fault, 2))
    or (##[0:2] any_fault))
    else $error("fault pin low with no fault flag");
endmodule : mfo_bank_monitor

bind mfo_bank mfo_bank_monitor #(.MS_CYC(MS_CYC), .DEV_ADDR(DEV_ADDR)) i_mon (
  .REF_CLK_IN(REF_CLK_IN), .SYS_RST_IN(SYS_RST_IN), .SCLK_IN(SCLK_IN),
  .CS_N_IN(CS_N_IN), .SDI_IN(SDI_IN), .AUX_RAW_IN(AUX_RAW_IN),
  .AUX_VALID_IN(AUX_VALID_IN), .CELL_MV_IN(CELL_MV_IN),
  .CRC_FAULT_CLR_IN(CRC_FAULT_CLR_IN), .OV_FAULT_CLR_IN(OV_FAULT_CLR_IN),
  .SDO_OUT(SDO_OUT), .SDO_OE_N_OUT(SDO_OE_N_OUT),
  .AUX_REF_SEL_OUT(AUX_REF_SEL_OUT), .AUX_SRC_SEL_OUT(AUX_SRC_SEL_OUT),
  .AUX_RESULT_OUT(AUX_RESULT_OUT), .CRC_FAULT_OUT(CRC_FAULT_OUT),
  .OV_FAULT_OUT(OV_FAULT_OUT), .FAULT_N_OUT(FAULT_N_OUT));
`default_nettype wire

// ===== bench/mfo_host_model.sv
// mfo_host_model: spi host for the bank, 125 ns serial clock in frames
// assumes the bank samples sdi on rise and drives sdo on fall
`timescale 1ns/100ps
`default_nettype none
module mfo_host_model (
  output logic      sclk_out,
  output logic      cs_n_out,
  output logic      sdi_out,
  input  wire logic sdo_in,
  input  wire logic sdo_oe_n_in
);
  logic crc_on;
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b1;
    sdi_out = 1'b0;
    crc_on = 1'b1;
  end
  function automatic logic [7:0] h_crc(input logic [7:0] c,
                                       input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction : h_crc
  //////////////////////////////////////////////////////////////////////////
  task automatic xfer(input logic [31:0] tx, input int ntx, input int nrx,
                      output logic [23:0] rx);
    rx = '0;
    tx = tx << (32 - ntx);
    #37 cs_n_out = 1'b0;
    for (int i = 0; i < ntx + nrx; i++) begin
      sdi_out = tx[31];
      tx = tx << 1;
      #62.5 sclk_out = 1'b1;
      // a released line reads inverted, so a missing enable shows up
      if (i >= ntx) rx = {rx[22:0], sdo_oe_n_in ? ~sdo_in : sdo_in};
      #62.5 sclk_out = 1'b0;
    end
    #62.5 cs_n_out = 1'b1;
    sdi_out = ~sdi_out;
    #1000;
  endtask : xfer
  task automatic wr(input logic [5:0] a, input logic [7:0] off,
                    input logic [7:0] d, input logic bad);
    logic [23:0] h;
    logic [7:0]  c;
    logic [23:0] rx;
    h = {1'b0, a, 1'b1, off, d};
    c = h_crc(h_crc(h_crc(8'h00, h[23:16]), h[15:8]), h[7:0]) ^ {7'h0, bad};
    if (crc_on) xfer({h, c}, 32, 0, rx);
    else xfer({8'h00, h}, 24, 0, rx);
  endtask : wr
  task automatic rd(input logic [5:0] a, input logic [7:0] off, input int n,
                    output logic [23:0] rx);
    xfer({9'h000, a, 1'b0, off, 8'(n)}, 24, 8 * n + (crc_on ? 8 : 0), rx);
  endtask : rd
endmodule : mfo_host_model
`default_nettype wire

// ===== bench/tb_monitor_feature_and_ov_config.sv
// tb_monitor_feature_and_ov_config: random and corner checks of the bank
// assumes mfo_host_model as spi host and the bound port monitor
`timescale 1ns/100ps
`default_nettype none
module tb_monitor_feature_and_ov_config;
  import mfo_pkg::*;
  localparam logic [5:0] DEV = 6'h05;
  logic                clk, rst, aux_valid, crc_clr, ov_clr, sclk, cs_n, sdi;
  logic                sdo, sdo_oe_n, ref_sel, src_sel, crc_f, fault_n;
  logic [13:0]         aux_raw;
  logic [15:0]         aux_res;
  logic [NCELL*13-1:0] cell_mv;
  logic [5:0]          ov_f, thr;
  logic [7:0]          d, dly;
  logic [12:0]         lvl;
  logic [23:0]         rx;
  int                  seed, bad_count, samples_checked;
  int                  cycles = 0;
  mfo_bank #(.MS_CYC(20), .DEV_ADDR(DEV)) i_dut (
    .REF_CLK_IN(clk), .SYS_RST_IN(rst), .SCLK_IN(sclk), .CS_N_IN(cs_n),
    .SDI_IN(sdi), .AUX_RAW_IN(aux_raw), .AUX_VALID_IN(aux_valid),
    .CELL_MV_IN(cell_mv), .CRC_FAULT_CLR_IN(crc_clr),
    .OV_FAULT_CLR_IN(ov_clr), .SDO_OUT(sdo), .SDO_OE_N_OUT(sdo_oe_n),
    .AUX_REF_SEL_OUT(ref_sel), .AUX_SRC_SEL_OUT(src_sel),
    .AUX_RESULT_OUT(aux_res), .CRC_FAULT_OUT(crc_f), .OV_FAULT_OUT(ov_f),
    .FAULT_N_OUT(fault_n));
  mfo_host_model i_host (.sclk_out(sclk), .cs_n_out(cs_n), .sdi_out(sdi),
    .sdo_in(sdo), .sdo_oe_n_in(sdo_oe_n));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  //////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] exp_aux(input logic s, input logic [13:0] r);
    logic [16:0] w;
    w = 17'(r) * 17'h5;
    return s ? w[16:1] : {2'h0, r};
  endfunction : exp_aux
  task automatic check(input string what, input logic [23:0] e,
                       input logic [23:0] g);
    samples_checked++;
    if (g !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] off, input logic [7:0] e);
    i_host.rd(DEV, off, 1, rx);
    if (i_host.crc_on) begin
      check("read data", 24'(e), 24'(rx[15:8]));
      check("read crc", 24'(i_host.h_crc(8'h00, e)), 24'(rx[7:0]));
    end else check("read data", 24'(e), 24'(rx[7:0]));
  endtask : rd_chk
  task automatic hold_clr();
    @(negedge clk);
    crc_clr = 1'b1;
    ov_clr = 1'b1;
    repeat (8) @(negedge clk);
    crc_clr = 1'b0;
    ov_clr = 1'b0;
  endtask : hold_clr
  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      summarize();
    end
  end
  //////////////////////////////////////////////////////////////////////////
  initial begin
    seed = 60;
    bad_count = 0;
    samples_checked = 0;
    {rst, aux_valid, aux_raw, cell_mv, crc_clr, ov_clr} = '0;
    rst = 1'b1;
    repeat (10) @(negedge clk);
    rst = 1'b0;
    repeat (4) @(negedge clk);
    for (int k = 0; k < 5; k++) rd_chk(8'h40 + 8'(k), 8'h00);
    for (int k = 0; k < 4; k++) begin
      d = 8'($random(seed));
      d[4:2] = {k[0], k[1:0]};
      i_host.wr(DEV, OFS_FEATURE, d, 1'b0);
      rd_chk(OFS_FEATURE, d & MSK_FEATURE);
      check("ref select", 24'(d[5]), 24'(ref_sel));
      check("src select", 24'(d[4]), 24'(src_sel));
      @(negedge clk);
      aux_raw = (k == 3) ? 14'h3FFF : 14'($random(seed));
      aux_valid = 1'b1;
      @(negedge clk);
      aux_valid = 1'b0;
      check("aux result", 24'(exp_aux(d[4], aux_raw)), 24'(aux_res));
      thr = 6'(($random(seed) & 32'hFF) % 61);
      dly = k[0] ? 8'hE1 : 8'h62;
      i_host.wr(DEV, OFS_OV_THR, {1'b0, 1'(k), thr}, 1'b0);
      i_host.wr(DEV, OFS_OV_DLY, dly, 1'b0);
      hold_clr();
      lvl = OV_BASE_MV + 13'(thr) * OV_STEP_MV;
      cell_mv = {{5{lvl + 13'h1}}, lvl};
      repeat (1880) @(negedge clk);
      check("ov early", 24'h0, 24'(ov_f));
      repeat (240) @(negedge clk);
      check("ov mask", 24'((6'h3F >> k) & 6'h3E), 24'(ov_f));
      cell_mv = '0;
      repeat (5) @(negedge clk);
      check("ov held", 24'((6'h3F >> k) & 6'h3E), 24'(ov_f));
    end
    i_host.rd(DEV, OFS_OV_THR, 2, rx);
    check("pair", {8'h0, 8'(thr) & MSK_OV_THR, 8'h81},
          {8'h0, rx[23:8]});
    i_host.wr(DEV, OFS_OV_DLY, 8'h00, 1'b0);
    i_host.wr(DEV, OFS_OV_THR, 8'h80, 1'b0);
    hold_clr();
    cell_mv = {6{13'h0FA0}};
    repeat (20) @(negedge clk);
    check("ov disabled", 24'h0, 24'(ov_f));
    i_host.wr(DEV, OFS_OV_THR, 8'h00, 1'b0);
    check("ov instant", 24'h7, 24'(ov_f));
    @(negedge clk);
    cell_mv = '0;
    repeat (5) @(negedge clk);
    check("ov unlatched", 24'h0, 24'(ov_f));
    i_host.wr(DEV, OFS_FEATURE, d ^ 8'h20, 1'b1);
    check("crc flag", 24'h1, 24'(crc_f));
    check("fault pin", 24'h0, 24'(fault_n));
    rd_chk(OFS_FEATURE, d & MSK_FEATURE);
    hold_clr();
    check("crc cleared", 24'h0, 24'(crc_f));
    i_host.wr(DEV, OFS_IO, 8'h80, 1'b0);
    i_host.wr(DEV, OFS_FEATURE, d, 1'b1);
    check("masked flag", 24'h1, 24'(crc_f));
    check("masked pin", 24'h1, 24'(fault_n));
    hold_clr();
    i_host.wr(6'h3F, OFS_IO, 8'hFF, 1'b0);
    i_host.crc_on = 1'b0;
    i_host.wr(DEV, OFS_FEATURE, 8'h00, 1'b0);
    rd_chk(OFS_IO, 8'h81);
    rd_chk(OFS_FEATURE, 8'h00);
    summarize();
  end
endmodule : tb_monitor_feature_and_ov_config
`default_nettype wire
